// ===== src/cfu_pkg.sv
/*
 Package of the compare flag unit: register map, field layouts, reset values,
 operation and mode encodings. Assumes a 32-bit classic Wishbone register bus.
*/
package cfu_pkg;

    localparam int unsigned CFU_DW = 32;
    localparam int unsigned CFU_AW = 8;

    // Register byte offsets
    localparam logic [7:0] CFU_OFS_CTRL = 8'h00;
    localparam logic [7:0] CFU_OFS_OPA = 8'h04;
    localparam logic [7:0] CFU_OFS_OPB = 8'h08;
    localparam logic [7:0] CFU_OFS_FLAGS = 8'h0C;
    localparam logic [7:0] CFU_OFS_DIFF = 8'h10;
    localparam logic [7:0] CFU_OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] CFU_OFS_IRQ_MASK = 8'h18;

    // Control register fields
    localparam int unsigned CFU_CTRL_GO = 0;
    localparam int unsigned CFU_CTRL_OP = 1;
    localparam int unsigned CFU_CTRL_MODE_LO = 2;
    localparam int unsigned CFU_CTRL_OVM = 4;
    localparam int unsigned CFU_CTRL_SRC1_MODE_LO = 8;
    localparam int unsigned CFU_CTRL_SRC2_MODE_LO = 10;
    localparam int unsigned CFU_CTRL_REG_LO = 16;
    localparam int unsigned CFU_CTRL_DST_LO = 24;

    // Flag register fields
    localparam int unsigned CFU_FLG_C = 0;
    localparam int unsigned CFU_FLG_V = 1;
    localparam int unsigned CFU_FLG_Z = 2;
    localparam int unsigned CFU_FLG_N = 3;
    localparam int unsigned CFU_FLG_UF = 4;
    localparam int unsigned CFU_FLG_LV = 5;
    localparam int unsigned CFU_FLG_LUF = 6;
    localparam int unsigned CFU_FLG_W = 7;

    localparam logic [6:0] CFU_FLAGS_RST = 7'h00;
    localparam logic [31:0] CFU_WORD_RST = 32'h0000_0000;
    localparam logic [1:0] CFU_IRQ_RST = 2'h0;

    // Interrupt status bits
    localparam int unsigned CFU_IRQ_DONE = 0;
    localparam int unsigned CFU_IRQ_EXC = 1;
    localparam int unsigned CFU_IRQ_W = 2;

    // Largest register numbers per compare
    localparam logic [4:0] CFU_FREG_MAX = 5'h07;
    localparam logic [4:0] CFU_IREG_MAX = 5'h1B;

    // Execute takes one cycle
    localparam int unsigned CFU_EXEC_CYCLES = 1;

    typedef enum logic
    {
        CFU_OP_FLOAT = 1'b0,
        CFU_OP_INT = 1'b1
    } cfu_op_e;

    typedef enum logic [1:0]
    {
        CFU_GM_REGISTER = 2'h0,
        CFU_GM_DIRECT = 2'h1,
        CFU_GM_INDIRECT = 2'h2,
        CFU_GM_IMMEDIATE = 2'h3
    } cfu_gmode_e;

    typedef struct packed
    {
        logic sticky_underflow_flag;
        logic lv;
        logic uf;
        logic n;
        logic z;
        logic v;
        logic c;
    } cfu_flags_s;

    typedef struct packed
    {
        logic [31:0] diff;
        logic n;
        logic z;
        logic v;
        logic uf;
        logic c;
    } cfu_result_s;

endpackage

// ===== src/cfu_float_sub.sv
/*
 Combinational float subtractor for the compare unit: a - b on the core's
 32-bit float word (8-bit two's-complement exponent, 24-bit signed mantissa
 with implied leading bit). Exponent -128 denotes zero.
*/
`timescale 1ns/1ps
`default_nettype none
module cfu_float_sub
    import cfu_pkg::*;
(
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    output cfu_result_s res_o
);

    logic signed [9:0] ea;
    logic signed [9:0] eb;
    logic signed [26:0] ma;
    logic signed [26:0] mb;
    logic signed [27:0] sum;
    logic signed [9:0] eres;
    logic [27:0] mag;
    logic [9:0] sh;
    logic [27:0] norm;
    logic [9:0] dexp;

    // Full mantissa: implied bit is 1 for positive, 0 for negative values
    function automatic logic signed [26:0] mant(input logic [31:0] w);
        logic signed [26:0] m;
        m = 27'sh0;
        if (w[31:24] != 8'h80)
        begin
            m = $signed({w[23], ~w[23], w[22:0], 2'b00});
        end
        return m;
    endfunction

    always_comb
    begin
        ea = $signed({{2{a_i[31]}}, a_i[31:24]});
        eb = $signed({{2{b_i[31]}}, b_i[31:24]});
        ma = mant(a_i);
        mb = mant(b_i);
        // Align the smaller operand; bits shifted past the guard are dropped
        if (ma == 27'sh0)
        begin
            eres = eb;
        end
        else if (mb == 27'sh0 || ea >= eb)
        begin
            eres = ea;
            mb = (ea - eb > 10'sd26) ? 27'sh0 : (mb >>> (ea - eb));
        end
        else
        begin
            eres = eb;
            ma = (eb - ea > 10'sd26) ? 27'sh0 : (ma >>> (eb - ea));
        end
        sum = 28'(ma) - 28'(mb);
        mag = sum[27] ? 28'(-sum) : sum;
        sh = 10'h000;
        for (int i = 0; i < 28; i++)
        begin
            if (mag[i])
            begin
                sh = 10'(27 - i);
            end
        end
        norm = mag << sh;
        // Mantissa weight is 2^-25 and the shift parks the leading one on bit 27
        dexp = 10'(eres + 10'sd2 - $signed(sh));
        res_o.n = sum[27];
        res_o.z = (sum == 28'sh0);
        res_o.c = 1'b0;
        res_o.v = !res_o.z && ($signed(dexp) > 10'sd127);
        res_o.uf = !res_o.z && ($signed(dexp) < -10'sd127);
        if (res_o.z || res_o.uf)
        begin
            res_o.diff = 32'h8000_0000;
        end
        else
        begin
            res_o.diff = {dexp[7:0], sum[27], norm[26:4]};
        end
    end

endmodule
`default_nettype wire

// ===== src/cfu_top.sv
/*
 Compare flag unit: executes the float three-operand compare and the integer
 compare, updating condition and sticky flags, behind a classic Wishbone slave.
 Assumes the decoder/pipeline has already fetched both operand values.
*/
// Notes on behaviour
// - Float compare computes first source minus second; no register is written.
// - Float compare treats both sources as floating-point values.
// - Float compare is decoded in the three-operand format.
// - First source mode 00/10 register 0-7, 01/11 indirect.
// - Second source mode 00/01 register 0-7, 10/11 indirect.
// - Negative and zero flags follow the difference for both compares.
// - Float compare sets overflow on float overflow, clears it otherwise.
// - Float compare sets underflow on float underflow; carry unchanged.
// - Float overflow sets sticky overflow; otherwise it keeps its value.
// - Float underflow sets sticky underflow; otherwise it keeps its value.
// - Overflow-saturation mode bit changes nothing in either compare.
// - Integer compare computes destination minus source; destination unmodified.
// - Integer compare treats operands as signed two's-complement integers.
// - Integer source mode 00 reg, 01 direct, 10 indirect, 11 immediate; regs 0-27.
// - Integer compare sets overflow on signed overflow, clears it otherwise.
// - Integer compare sets carry on borrow, clears it otherwise.
// - Integer overflow sets sticky overflow; underflow forced 0; sticky underflow kept.
`timescale 1ns/1ps
`default_nettype none
module cfu_top
    import cfu_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CFU_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [CFU_DW-1:0] wb_dat_i,
    output logic [CFU_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic irq_o,
    output cfu_flags_s flags_o,
    output logic done_o
);

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] opa_q;
    logic [31:0] opa_d;
    logic [31:0] opb_q;
    logic [31:0] opb_d;
    logic [31:0] diff_q;
    logic [31:0] diff_d;
    cfu_flags_s flg_q;
    cfu_flags_s flg_d;
    logic [CFU_IRQ_W-1:0] ist_q;
    logic [CFU_IRQ_W-1:0] ist_d;
    logic [CFU_IRQ_W-1:0] imsk_q;
    logic [CFU_IRQ_W-1:0] imsk_d;
    logic ack_q;
    logic ack_d;
    logic err_q;
    logic err_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic done_q;
    logic done_d;

    logic req;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] wmask;
    logic [31:0] rword;
    logic go;
    cfu_op_e op;
    logic bad_operand;
    logic src1_reg;
    logic src2_reg;
    logic src_reg;
    logic [4:0] src_num;
    logic [4:0] dst_num;
    logic [1:0] m1;
    logic [1:0] m2;
    logic [1:0] gm;
    cfu_result_s fres;
    cfu_result_s ires;
    logic [32:0] iwide;
    logic [CFU_IRQ_W-1:0] ev;

    // Operand words hold fetched values; the unit never writes them back
    cfu_float_sub u_fsub
    (
        .a_i(opa_q),
        .b_i(opb_q),
        .res_o(fres)
    );

    // Integer subtract: destination minus source, signed
    always_comb
    begin
        iwide = {1'b0, opa_q} - {1'b0, opb_q};
        ires.diff = iwide[31:0];
        ires.n = iwide[31];
        ires.z = (iwide[31:0] == 32'h0000_0000);
        ires.v = (opa_q[31] != opb_q[31]) && (iwide[31] != opa_q[31]);
        ires.c = iwide[32];
        ires.uf = 1'b0;
    end

    // Bus decode; one wait state so ack is registered and drops next cycle
    always_comb
    begin
        req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
        wr = req && wb_we_i;
        rd = req && !wb_we_i;
        mapped = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= CFU_OFS_IRQ_MASK);
        for (int i = 0; i < 4; i++)
        begin
            wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
        end
        case (wb_adr_i)
            CFU_OFS_CTRL: rword = ctrl_q;
            CFU_OFS_OPA: rword = opa_q;
            CFU_OFS_OPB: rword = opb_q;
            CFU_OFS_FLAGS: rword = {25'h0, flg_q};
            CFU_OFS_DIFF: rword = diff_q;
            CFU_OFS_IRQ_STAT: rword = {30'h0, ist_q};
            CFU_OFS_IRQ_MASK: rword = {30'h0, imsk_q};
            default: rword = 32'h0000_0000;
        endcase
    end

    // Instruction decode from the control word
    always_comb
    begin
        op = cfu_op_e'(ctrl_q[CFU_CTRL_OP]);
        m1 = ctrl_q[CFU_CTRL_SRC1_MODE_LO +: 2];
        m2 = ctrl_q[CFU_CTRL_SRC2_MODE_LO +: 2];
        gm = ctrl_q[CFU_CTRL_MODE_LO +: 2];
        go = ctrl_q[CFU_CTRL_GO];
        src_num = ctrl_q[CFU_CTRL_REG_LO +: 5];
        dst_num = ctrl_q[CFU_CTRL_DST_LO +: 5];
        // Three-operand format: bit 0 of src1 mode, bit 1 of src2 mode pick indirect
        src1_reg = !m1[0];
        src2_reg = !m2[1];
        src_reg = (cfu_gmode_e'(gm) == CFU_GM_REGISTER);
        // Register numbers are checked only for register modes; indirect is fetched outside
        case (op)
            CFU_OP_FLOAT:
            begin
                bad_operand = (src1_reg && src_num > CFU_FREG_MAX)
                    || (src2_reg && dst_num > CFU_FREG_MAX);
            end
            CFU_OP_INT:
            begin
                // The destination is always a register
                bad_operand = (src_reg && src_num > CFU_IREG_MAX) || dst_num > CFU_IREG_MAX;
            end
            default:
            begin
                bad_operand = 1'b0;
            end
        endcase
    end

    // Bus answer group: ack or err one cycle after the request is taken
    always_comb
    begin
        ack_d = 1'b0;
        err_d = 1'b0;
        rdat_d = rdat_q;
        // Req is masked while an answer stands, so a strobe held into the answer cycle is not answered twice
        if (req)
        begin
            ack_d = mapped;
            err_d = !mapped;
            rdat_d = rword;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= CFU_WORD_RST;
        end
        else
        begin
            ack_q <= ack_d;
            err_q <= err_d;
            rdat_q <= rdat_d;
        end
    end

    // Register group: control word, operand words and interrupt mask
    always_comb
    begin
        ctrl_d = ctrl_q;
        opa_d = opa_q;
        opb_d = opb_q;
        imsk_d = imsk_q;
        // Go is a one-shot; a write in the same cycle may set it again
        ctrl_d[CFU_CTRL_GO] = 1'b0;
        if (wr && mapped)
        begin
            case (wb_adr_i)
                CFU_OFS_CTRL: ctrl_d = (ctrl_q & ~wmask) | (wb_dat_i & wmask);
                CFU_OFS_OPA: opa_d = (opa_q & ~wmask) | (wb_dat_i & wmask);
                CFU_OFS_OPB: opb_d = (opb_q & ~wmask) | (wb_dat_i & wmask);
                CFU_OFS_IRQ_MASK:
                begin
                    if (wb_sel_i[0])
                    begin
                        imsk_d = wb_dat_i[CFU_IRQ_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_q <= CFU_WORD_RST;
            opa_q <= CFU_WORD_RST;
            opb_q <= CFU_WORD_RST;
            imsk_q <= CFU_IRQ_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            opa_q <= opa_d;
            opb_q <= opb_d;
            imsk_q <= imsk_d;
        end
    end

    // Execute group: flags, difference and done pulse settle in one cycle
    always_comb
    begin
        diff_d = diff_q;
        flg_d = flg_q;
        done_d = 1'b0;
        ev = '0;
        // The overflow-saturation bit is stored but never consulted
        if (go)
        begin
            done_d = 1'b1;
            ev[CFU_IRQ_DONE] = 1'b1;
            // Sticky flags only gain bits here; reset alone clears them
            case (op)
                CFU_OP_FLOAT:
                begin
                    // Carry has no float meaning, so this branch leaves it alone
                    diff_d = fres.diff;
                    flg_d.n = fres.n;
                    flg_d.z = fres.z;
                    flg_d.v = fres.v;
                    flg_d.uf = fres.uf;
                    flg_d.lv = flg_q.lv | fres.v;
                    flg_d.sticky_underflow_flag = flg_q.sticky_underflow_flag | fres.uf;
                end
                CFU_OP_INT:
                begin
                    diff_d = ires.diff;
                    flg_d.n = ires.n;
                    flg_d.z = ires.z;
                    flg_d.v = ires.v;
                    flg_d.c = ires.c;
                    flg_d.uf = 1'b0;
                    flg_d.lv = flg_q.lv | ires.v;
                end
                default: ;
            endcase
            ev[CFU_IRQ_EXC] = bad_operand | flg_d.v | flg_d.uf;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            diff_q <= CFU_WORD_RST;
            flg_q <= CFU_FLAGS_RST;
            done_q <= 1'b0;
        end
        else
        begin
            diff_q <= diff_d;
            flg_q <= flg_d;
            done_q <= done_d;
        end
    end

    // Interrupt group: read clears status, but an event in the same cycle survives
    always_comb
    begin
        ist_d = ist_q;
        if (rd && wb_adr_i == CFU_OFS_IRQ_STAT)
        begin
            ist_d = '0;
        end
        ist_d = ist_d | ev;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ist_q <= CFU_IRQ_RST;
        end
        else
        begin
            ist_q <= ist_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;
    assign irq_o = |(ist_q & imsk_q);
    assign flags_o = flg_q;
    assign done_o = done_q;

endmodule
`default_nettype wire

// ===== test/cfu_top_chk.sv
/*
 Port checker of the compare flag unit: bus answer timing and flag updates.
 Assumes a single clock domain and is bound onto the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module cfu_top_chk
    import cfu_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CFU_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [CFU_DW-1:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire cfu_flags_s flags_o,
    input wire logic done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    bus_answer_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o != wb_err_o)
        else $error("request not answered one cycle later");
    unmapped_err_a: assert property ($rose(wb_cyc_i && wb_stb_i)
        && (wb_adr_i > 8'h18 || wb_adr_i[1:0] != 2'h0) |=> wb_err_o)
        else $error("unmapped access without err");
    // Go lands with the write, executes one edge later, and done shows after that edge
    go_done_a: assert property ($rose(wb_cyc_i && wb_stb_i) && wb_we_i
        && wb_adr_i == CFU_OFS_CTRL && wb_sel_i[0] && wb_dat_i[CFU_CTRL_GO] |-> ##2 done_o)
        else $error("compare did not complete");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    flags_done_a: assert property ($changed(flags_o) |-> done_o)
        else $error("flags moved without a compare");
    sticky_keep_a: assert property (!$fell(flags_o.lv) && !$fell(flags_o.sticky_underflow_flag))
        else $error("sticky flag cleared");
    ovf_sticky_a: assert property (flags_o.v |-> flags_o.lv)
        else $error("overflow without sticky overflow");
    unf_sticky_a: assert property (flags_o.uf |-> flags_o.sticky_underflow_flag)
        else $error("underflow without sticky underflow");

    cover property (done_o && flags_o.v);
    cover property (done_o && flags_o.uf);
    cover property (wb_err_o);
endmodule

bind cfu_top cfu_top_chk u_chk (.clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .flags_o, .done_o);
`default_nettype wire

// ===== test/cfu_core_model.sv
/*
 Core side model: issues classic Wishbone accesses for the pipeline.
 Assumes xfer is called just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cfu_core_model
    import cfu_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [CFU_DW-1:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [CFU_AW-1:0] adr_o,
    output logic [3:0] sel_o,
    output logic [CFU_DW-1:0] dat_o
);
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'hF;
        dat_o = 32'h0;
    end

    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        input int gap, output logic [31:0] rv, output logic er);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        dat_o <= dat;
        do
            @(posedge clk_i);
        while (!(ack_i || err_i));
        rv = dat_i;
        er = err_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Stale write data is inverted so it never passes for a live value
        dat_o <= ~dat;
        repeat (gap + 1) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
/*
 Self-checking bench of the compare flag unit with an integer flag model.
 Assumes the checker is bound and the core model drives the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
    import cfu_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wb_cyc, wb_stb, wb_we, wb_ack, wb_err, irq, done;
    logic [3:0] wb_sel;
    logic [CFU_AW-1:0] wb_adr;
    logic [CFU_DW-1:0] wb_wdat, wb_rdat, rv;
    cfu_flags_s flags;
    int err_count = 0;
    int checked = 0;
    int seed = 53;
    int cycles = 0;
    logic lv_m, luf_m, c_m;
    logic [31:0] ia [5] = '{32'h80000000, 32'h0, 32'h7FFFFFFF, 32'h3E8, 32'h5};
    logic [31:0] ib [5] = '{32'h1, 32'h1, 32'hFFFFFFFF, 32'h898, 32'h5};
    logic [31:0] fa [5] = '{32'h0, 32'h077A7000, 32'h057A2000, 32'h7F400000, 32'h81400000};
    logic [31:0] fb [5] = '{32'h01000000, 32'h077A7000, 32'h077A7000, 32'h7FC00000, 32'h81000000};
    logic [3:0] fe [5] = '{4'h8, 4'h4, 4'h8, 4'h2, 4'h1};

    always #5 clk_i = ~clk_i;

    cfu_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .wb_err_o(wb_err), .irq_o(irq),
        .flags_o(flags), .done_o(done));
    cfu_core_model u_core (.clk_i(clk_i), .ack_i(wb_ack), .err_i(wb_err), .dat_i(wb_rdat),
        .cyc_o(wb_cyc), .stb_o(wb_stb), .we_o(wb_we), .adr_o(wb_adr), .sel_o(wb_sel),
        .dat_o(wb_wdat));

    task automatic wrap_up;
        $display("errors %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [6:0] exp, input logic [6:0] m);
        checked++;
        if ((flags & m) !== (exp & m))
        begin
            err_count++;
            $display("MISMATCH %0t flags %b expected %b", $time, flags, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        logic er;
        u_core.xfer(we, adr, dat, {$random(seed)} % 3, rd, er);
        chk_word({31'h0, er}, {31'h0, adr > 8'h18});
    endtask

    task automatic run_cmp(input logic op, input logic [31:0] a, input logic [31:0] b,
        input logic [3:0] fz, input logic [6:0] m);
        logic [31:0] ct;
        logic [31:0] r;
        logic v;
        // Random modes, register numbers and saturation bit must not matter
        ct = ($random(seed) & 32'h1F1F0F1C) | {30'h0, op, 1'b1};
        r = a - b;
        v = (a[31] != b[31]) && (r[31] != a[31]);
        if (op)
        begin
            c_m = a < b;
            fz = {r[31], r == 32'h0, v, 1'b0};
        end
        lv_m = lv_m | fz[1];
        luf_m = luf_m | fz[0];
        bus(1'b1, CFU_OFS_OPA, a, rv);
        bus(1'b1, CFU_OFS_OPB, b, rv);
        bus(1'b1, CFU_OFS_CTRL, ct, rv);
        repeat (2) @(posedge clk_i);
        chk_flags({luf_m, lv_m, fz[0], fz[3:2], fz[1], c_m}, m);
        bus(1'b0, CFU_OFS_OPA, 32'h0, rv);
        chk_word(rv, a);
        bus(1'b0, CFU_OFS_OPB, 32'h0, rv);
        chk_word(rv, b);
        if (op)
        begin
            bus(1'b0, CFU_OFS_DIFF, 32'h0, rv);
            chk_word(rv, r);
        end
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            err_count++;
            wrap_up;
        end
    end

    initial
    begin
        lv_m = 1'b0;
        luf_m = 1'b0;
        c_m = 1'b0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        chk_flags(7'h00, 7'h7F);
        for (int i = 0; i < 25; i++)
            run_cmp(1'b1, i < 5 ? ia[i % 5] : $random(seed), i < 5 ? ib[i % 5] : $random(seed),
                4'h0, 7'h7F);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        lv_m = 1'b0;
        luf_m = 1'b0;
        c_m = 1'b0;
        @(posedge clk_i);
        run_cmp(1'b1, 32'h0, 32'h1, 4'h0, 7'h7F);
        // Sign and zero are left open on overflow and underflow results
        for (int i = 0; i < 5; i++)
            run_cmp(1'b0, fa[i], fb[i], fe[i], i < 3 ? 7'h7F : 7'h73);
        bus(1'b1, CFU_OFS_IRQ_MASK, 32'h1, rv);
        run_cmp(1'b1, 32'h7, 32'h7, 4'h0, 7'h7F);
        chk_word({31'h0, irq}, 32'h1);
        bus(1'b0, CFU_OFS_IRQ_STAT, 32'h0, rv);
        chk_word(rv & 32'h3, 32'h3);
        chk_word({31'h0, irq}, 32'h0);
        bus(1'b1, CFU_OFS_IRQ_MASK, 32'h0, rv);
        run_cmp(1'b1, 32'h1, 32'h9, 4'h0, 7'h7F);
        chk_word({31'h0, irq}, 32'h0);
        bus(1'b0, 8'h1C, 32'h0, rv);
        wrap_up;
    end
endmodule
`default_nettype wire
